// file: logic/ltc_prbs_gen.sv
`timescale 1ns/100ps
`default_nettype none

module ltc_prbs_gen #(
  parameter int LFSR_W = 15,
  parameter int TAP_A = 15,
  parameter int TAP_B = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Stepping
  input wire logic step,
  input wire logic injectErr,
  // Pattern
  output logic bitOut
);
  import ltc_pkg::*;

  logic [LFSR_W-1:0] lfsr_q;
  logic feedback;

  generate
    if (LFSR_W < 2 || TAP_A > LFSR_W || TAP_B > LFSR_W || TAP_A < 1 || TAP_B < 1) begin : g_bad
      $error("ltc_prbs_gen: taps outside register");
    end
  endgenerate

  assign feedback = lfsr_q[TAP_A-1] ^ lfsr_q[TAP_B-1];

  // All-ones seed keeps the register out of the locked zero state
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lfsr_q <= '1;
    end else if (step) begin
      lfsr_q <= {lfsr_q[LFSR_W-2:0], feedback};
    end
  end

  // Error flips only the emitted bit, the sequence itself stays intact
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bitOut <= 1'b0;
    end else if (step) begin
      bitOut <= feedback ^ injectErr;
    end
  end
endmodule

`default_nettype wire

// file: logic/ltc_tx_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "ltc_regs.svh"

// Behaviour
// [R01] Transmit control for channel 1 sits at offset 0x0c and resets to all zeros.
// [R02] Monitor select 0 watches the external monitor inputs, 1 watches internally.
// [R03] Internal monitoring looks at the driven line outputs, needing no monitor inputs.
// [R04] A 0 to 1 change of the error bit corrupts exactly one PRBS output bit.
// [R05] The error bit is ignored unless PRBS generator and receiver are both enabled.
// [R06] Software must write the error bit back to 0 before asking for another error.
// [R07] With all-ones set, system data is dropped and unframed all-ones marks go out.
// [R08] With all-ones clear, system data goes out untouched by the override; the code sends PRBS data instead while the generator is enabled.
// [R09] Clock-edge bit 0 samples rail data on the falling edge, 1 on the rising edge.
// [R10] Build-out bit is ignored in E3 mode.
// [R11] Alarm rises after 128 bit periods without pulses and clears on any pulse.
// [R12] Bits 7, 6 and 3 read as zero and ignore writes.
module ltc_tx_control #(
  parameter int DMO_LIMIT = `LTC_DMO_BITS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire ltc_pkg::ltc_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ltc_pkg::ltc_word_t pwdata,
  input wire logic [3:0] pstrb,
  output ltc_pkg::ltc_word_t prdata,
  output logic pready,
  output logic pslverr,
  // System-side transmit input
  input wire logic tx_data_clock,
  input wire logic tx_positive_rail_data,
  input wire logic tx_negative_rail_data,
  // Line side
  output logic line_out_positive,
  output logic line_out_negative,
  input wire logic monitor_in_positive,
  input wire logic monitor_in_negative,
  output logic line_buildout_select,
  output logic drive_monitor_alarm,
  // Interrupt
  output logic irq
);
  import ltc_pkg::*;

  generate
    if (DMO_LIMIT < 2 || DMO_LIMIT > 255) begin : g_bad_limit
      $error("ltc_tx_control: DMO_LIMIT out of range");
    end
  endgenerate

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta_q;
  logic rstSync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Order: clock, pos data, neg data, mon pos, mon neg
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  logic clkPrev_q;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinMeta_q <= 5'h00;
      pinSync_q <= 5'h00;
    end else begin
      pinMeta_q <= {tx_data_clock, tx_positive_rail_data, tx_negative_rail_data,
                    monitor_in_positive, monitor_in_negative};
      pinSync_q <= pinMeta_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      clkPrev_q <= 1'b0;
    end else begin
      clkPrev_q <= pinSync_q[4];
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] txCtrl_q;
  logic [2:0] cfg_q;
  logic [2:0] istat_q;
  logic [2:0] imask_q;
  logic errPend_q;
  logic [2:0] events;
  ltc_mon_state_t monState_q;

  logic setupPh;
  logic apbDone;
  logic wrDone;
  logic rdDone;
  logic addrHit;
  logic [7:0] txCtrl_d;
  logic prbsGenEn;
  logic prbsRxEn;
  logic e3Mode;

  assign setupPh = psel && !penable;
  assign apbDone = psel && penable && pready;
  assign wrDone = apbDone && pwrite && !pslverr && pstrb[0];
  assign rdDone = apbDone && !pwrite;
  assign prbsGenEn = cfg_q[`LTC_CFG_GEN_EN];
  assign prbsRxEn = cfg_q[`LTC_CFG_RX_EN];
  assign e3Mode = cfg_q[`LTC_CFG_E3];
  assign txCtrl_d = pwdata[7:0] & `LTC_TXC_WMASK; // [R12]

  always_comb begin
    unique case (paddr)
      `LTC_TXCTRL_OFS, `LTC_CFG_OFS, `LTC_ISTAT_OFS, `LTC_IMASK_OFS, `LTC_LSTAT_OFS: begin
        addrHit = 1'b1;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Answer is prepared in setup so pready comes straight from a flop
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh && !addrHit;
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh) begin
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `LTC_TXCTRL_OFS: prdata[7:0] <= txCtrl_q;
          `LTC_CFG_OFS: prdata[2:0] <= cfg_q;
          `LTC_ISTAT_OFS: prdata[2:0] <= istat_q;
          `LTC_IMASK_OFS: prdata[2:0] <= imask_q;
          `LTC_LSTAT_OFS: prdata[1:0] <= {errPend_q, monState_q == LTC_MON_ALARM};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txCtrl_q <= `LTC_TXC_RESET; // [R01]
    end else if (wrDone && paddr == `LTC_TXCTRL_OFS) begin
      txCtrl_q <= txCtrl_d; // [R01]
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfg_q <= `LTC_CFG_RESET;
    end else if (wrDone && paddr == `LTC_CFG_OFS) begin
      cfg_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      imask_q <= `LTC_EV_RESET;
    end else if (wrDone && paddr == `LTC_IMASK_OFS) begin
      imask_q <= pwdata[2:0];
    end
  end

  // ----------------------------------------
  // Sticky status and interrupt
  // ----------------------------------------
  // Only bits that were reported get cleared; a new event always wins
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      istat_q <= `LTC_EV_RESET;
    end else if (rdDone && paddr == `LTC_ISTAT_OFS) begin
      istat_q <= (istat_q & ~prdata[2:0]) | events;
    end else begin
      istat_q <= istat_q | events;
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_q & imask_q);
    end
  end

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  logic bitStrobe;
  logic railPos;
  logic railNeg;

  assign railPos = pinSync_q[3];
  assign railNeg = pinSync_q[2];
  assign bitStrobe = (pinSync_q[4] != clkPrev_q) &&
                     (pinSync_q[4] == txCtrl_q[`LTC_TXC_EDGE]); // [R09]

  // ----------------------------------------
  // Single error insertion
  // ----------------------------------------
  logic errBitPrev_q;
  logic errRise;
  logic errUse;
  logic prbsBit;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      errBitPrev_q <= 1'b0;
    end else begin
      errBitPrev_q <= txCtrl_q[`LTC_TXC_INSERR];
    end
  end

  // Holding the bit at 1 never re-arms; software must return it to 0
  assign errRise = txCtrl_q[`LTC_TXC_INSERR] && !errBitPrev_q; // [R04] [R06]
  assign errUse = errPend_q && bitStrobe && prbsGenEn;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      errPend_q <= 1'b0;
    end else if (!(prbsGenEn && prbsRxEn)) begin
      errPend_q <= 1'b0; // [R05]
    end else if (errRise) begin
      errPend_q <= 1'b1; // [R04]
    end else if (errUse) begin
      errPend_q <= 1'b0;
    end
  end

  ltc_prbs_gen #(
    .LFSR_W(15),
    .TAP_A(15),
    .TAP_B(14)
  ) u_prbs (
    .clk(core_clk),
    .rstN(rstSync_n),
    .step(bitStrobe && prbsGenEn),
    .injectErr(errUse), // [R04]
    .bitOut(prbsBit)
  );

  // ----------------------------------------
  // Line output
  // ----------------------------------------
  // Generated marks alternate polarity so the line stays balanced
  logic markPol_q;
  logic genMark;

  assign genMark = txCtrl_q[`LTC_TXC_ALLONES] || prbsBit;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      line_out_positive <= 1'b0;
      line_out_negative <= 1'b0;
      markPol_q <= 1'b0;
    end else if (bitStrobe) begin
      if (txCtrl_q[`LTC_TXC_ALLONES] || prbsGenEn) begin
        line_out_positive <= genMark && !markPol_q; // [R07]
        line_out_negative <= genMark && markPol_q; // [R07]
        markPol_q <= markPol_q ^ genMark;
      end else begin
        line_out_positive <= railPos; // [R08]
        line_out_negative <= railNeg; // [R08]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      line_buildout_select <= 1'b0;
    end else begin
      line_buildout_select <= txCtrl_q[`LTC_TXC_BUILDOUT] && !e3Mode; // [R10]
    end
  end

  // ----------------------------------------
  // Drive monitor
  // ----------------------------------------
  logic activity;
  logic [7:0] idleCnt_q;
  logic limitHit;

  assign activity = txCtrl_q[`LTC_TXC_INTMON] ?
                    (line_out_positive || line_out_negative) : // [R02] [R03]
                    (pinSync_q[1] || pinSync_q[0]); // [R02]
  assign limitHit = bitStrobe && (idleCnt_q == 8'(DMO_LIMIT - 1));

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      idleCnt_q <= 8'h00;
    end else if (activity) begin
      idleCnt_q <= 8'h00;
    end else if (bitStrobe && monState_q == LTC_MON_OK) begin
      idleCnt_q <= limitHit ? 8'h00 : idleCnt_q + 8'h01; // [R11]
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      monState_q <= LTC_MON_OK;
    end else begin
      unique case (monState_q)
        LTC_MON_OK: begin
          if (!activity && limitHit) begin
            monState_q <= LTC_MON_ALARM; // [R11]
          end
        end
        LTC_MON_ALARM: begin
          if (activity) begin
            monState_q <= LTC_MON_OK; // [R11]
          end
        end
        default: monState_q <= LTC_MON_OK;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      drive_monitor_alarm <= 1'b0;
    end else begin
      drive_monitor_alarm <= (monState_q == LTC_MON_OK) ? (!activity && limitHit) : !activity;
    end
  end

  assign events = {errUse,
                   (monState_q == LTC_MON_ALARM) && activity,
                   (monState_q == LTC_MON_OK) && !activity && limitHit};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync_n);

  AST_TXCTRL_WRITE: assert property ( // [R01]
    wrDone && paddr == `LTC_TXCTRL_OFS |=> txCtrl_q == ($past(pwdata[7:0]) & 8'h37))
    else $error("Transmit control write not stored");

  AST_UNUSED_ZERO: assert property ( // [R12]
    txCtrl_q[7:6] == 2'b00 && !txCtrl_q[3])
    else $error("Unused transmit control bits set");

  AST_INT_MONITOR: assert property ( // [R03]
    txCtrl_q[5] && (line_out_positive || line_out_negative) |=> !drive_monitor_alarm)
    else $error("Internal line pulse did not clear alarm");

  AST_EXT_MONITOR: assert property ( // [R02]
    !txCtrl_q[5] && (pinSync_q[1] || pinSync_q[0]) |=> !drive_monitor_alarm)
    else $error("External monitor pulse did not clear alarm");

  AST_ALARM_RAISE: assert property ( // [R11]
    limitHit && !activity && !drive_monitor_alarm |=> drive_monitor_alarm)
    else $error("Alarm not raised at idle limit");

  AST_ALARM_EARLY: assert property ( // [R11]
    $rose(drive_monitor_alarm) |-> $past(idleCnt_q) == 8'(DMO_LIMIT - 1))
    else $error("Alarm raised before idle limit");

  AST_ERR_ONCE: assert property ( // [R04]
    errRise && prbsGenEn && prbsRxEn |=> ##[0:40] errUse ##1 !errPend_q)
    else $error("Requested bit error not inserted once");

  AST_ERR_GATED: assert property ( // [R05]
    errRise && !(prbsGenEn && prbsRxEn) |=> !errPend_q)
    else $error("Error request taken while PRBS disabled");

  AST_ALL_ONES: assert property ( // [R07]
    txCtrl_q[2] && bitStrobe |=> line_out_positive != line_out_negative)
    else $error("All-ones override sent a space");

  AST_PASS_DATA: assert property ( // [R08]
    !txCtrl_q[2] && !prbsGenEn && bitStrobe |=>
      line_out_positive == $past(tx_positive_rail_data, 3) &&
      line_out_negative == $past(tx_negative_rail_data, 3))
    else $error("System data altered");

  AST_SAMPLE_EDGE: assert property ( // [R09]
    bitStrobe |-> $past(tx_data_clock, 2) == txCtrl_q[1] &&
      $past(tx_data_clock, 3) != txCtrl_q[1])
    else $error("Rail data sampled on wrong clock edge");

  AST_E3_BUILDOUT: assert property ( // [R10]
    e3Mode |=> !line_buildout_select)
    else $error("Build-out driven in E3 mode");
endmodule

`default_nettype wire

// file: pkg/ltc_pkg.sv
package ltc_pkg;
  typedef logic [7:0] ltc_addr_t;
  typedef logic [31:0] ltc_word_t;
  typedef enum logic [1:0] {
    LTC_MON_OK = 2'b01,
    LTC_MON_ALARM = 2'b10
  } ltc_mon_state_t;
endpackage

// file: pkg/ltc_regs.svh
`ifndef LTC_REGS_SVH
`define LTC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define LTC_TXCTRL_OFS 8'h0c
`define LTC_CFG_OFS 8'h10
`define LTC_ISTAT_OFS 8'h14
`define LTC_IMASK_OFS 8'h18
`define LTC_LSTAT_OFS 8'h1c

// ----------------------------------------
// Transmit control fields
// ----------------------------------------
`define LTC_TXC_BUILDOUT 0
`define LTC_TXC_EDGE 1
`define LTC_TXC_ALLONES 2
`define LTC_TXC_INSERR 4
`define LTC_TXC_INTMON 5
`define LTC_TXC_WMASK 8'h37
`define LTC_TXC_RESET 8'h00

// ----------------------------------------
// Channel configuration fields
// ----------------------------------------
`define LTC_CFG_GEN_EN 0
`define LTC_CFG_RX_EN 1
`define LTC_CFG_E3 2
`define LTC_CFG_RESET 3'h0

// ----------------------------------------
// Interrupt fields and timing
// ----------------------------------------
`define LTC_EV_ALARM_SET 0
`define LTC_EV_ALARM_CLR 1
`define LTC_EV_ERR_DONE 2
`define LTC_EV_RESET 3'h0
`define LTC_DMO_BITS 128

`endif

// file: tb/ltc_framer_model.sv
`timescale 1ns/100ps
`default_nettype none

module ltc_framer_model (
  // Control from the bench
  input wire logic run,
  input wire logic edgeSel,
  input wire logic nextPos,
  input wire logic nextNeg,
  // Transmit side toward the block
  output logic tx_data_clock,
  output logic tx_positive_rail_data,
  output logic tx_negative_rail_data
);
  initial begin
    tx_data_clock = 1'b0;
    tx_positive_rail_data = 1'b0;
    tx_negative_rail_data = 1'b1;
    forever begin
      if (run) begin
        #400 tx_data_clock = 1'b1;
        // Launch on the edge that is not sampled, so data is stable there
        if (!edgeSel) begin
          tx_positive_rail_data = nextPos;
          tx_negative_rail_data = nextNeg;
        end
        #400 tx_data_clock = 1'b0;
        if (edgeSel) begin
          tx_positive_rail_data = nextPos;
          tx_negative_rail_data = nextNeg;
        end
      end else begin
        // Clock stands still between frames; released rails keep moving
        #400 tx_positive_rail_data = ~tx_positive_rail_data;
        tx_negative_rail_data = ~tx_negative_rail_data;
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  import ltc_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, monP, monN, run, edgeSel, nP, nN;
  logic pready, pslverr, txClk, txP, txN, lineP, lineN, buildout, alarm, irq, err, prevP;
  logic [3:0] pstrb;
  ltc_addr_t paddr;
  ltc_word_t pwdata, prdata, rd, d;
  int fail_count, checks_done;

  ltc_tx_control #(.DMO_LIMIT(8)) ltc_tx_control_inst (
    .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_data_clock(txClk), .tx_positive_rail_data(txP),
    .tx_negative_rail_data(txN), .line_out_positive(lineP), .line_out_negative(lineN),
    .monitor_in_positive(monP), .monitor_in_negative(monN),
    .line_buildout_select(buildout), .drive_monitor_alarm(alarm), .irq(irq));

  ltc_framer_model ltc_framer_model_inst (
    .run(run), .edgeSel(edgeSel), .nextPos(nP), .nextNeg(nN), .tx_data_clock(txClk),
    .tx_positive_rail_data(txP), .tx_negative_rail_data(txN));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input ltc_word_t exp, input ltc_word_t got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input ltc_addr_t a, input ltc_word_t wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("[ERR] pready expected 1 seen timeout");
      summarize();
    end
  endtask

  function automatic ltc_word_t expTxCtrl(input ltc_word_t w);
    return w & 32'h0000_0037;
  endfunction

  // Polls the link clock so a stalled framer cannot hang the run
  task automatic sampleEdge();
    int n;
    n = 0;
    while (txClk === edgeSel && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    while (txClk !== edgeSel && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      $display("[ERR] link_clock expected edge seen timeout");
      summarize();
    end
  endtask

  task automatic errStep(input ltc_word_t c, input ltc_word_t e);
    apb(1'b1, 8'h0c, c);
    #2400;
    apb(1'b0, 8'h14, 32'h0);
    chk("err_event", e, rd & 32'h4);
  endtask

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    {rst_n, psel, penable, pwrite, monP, monN, run, edgeSel, nP, nN} = '0;
    pstrb = 4'hf;
    paddr = '0;
    pwdata = '0;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(95065));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("reset_outs", 32'h0, {27'h0, lineP, lineN, buildout, alarm, irq});
    apb(1'b0, 8'h0c, 32'h0);
    chk("txctrl_reset", 32'h0, rd);
    chk("txctrl_err", 32'h0, {31'h0, err});
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 32'hff : $urandom;
      apb(1'b1, 8'h0c, d);
      apb(1'b0, 8'h0c, 32'h0);
      chk("txctrl_rw", expTxCtrl(d), rd);
    end
    // Write with byte 0 strobe off must leave the register alone
    d = 32'h35;
    apb(1'b1, 8'h0c, d);
    pstrb <= 4'he;
    apb(1'b1, 8'h0c, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, 8'h0c, 32'h0);
    chk("txctrl_strb", expTxCtrl(d), rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    $display("test registers done");
    run <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, 8'h0c, 32'(e << 1));
      edgeSel <= e[0];
      repeat (2) sampleEdge();
      for (int i = 0; i < 8; i++) begin
        sampleEdge();
        d = {30'h0, txP, txN};
        @(posedge core_clk);
        d[4:2] = 3'($urandom % 3);
        nP <= (d[4:2] == 3'h1);
        nN <= (d[4:2] == 3'h2);
        #600;
        chk("line_out", d & 32'h3, {30'h0, lineP, lineN});
      end
    end
    $display("test passthrough done");
    nP <= 1'b0;
    nN <= 1'b0;
    // Keep the rising sample edge so it matches the bench's edge select
    apb(1'b1, 8'h0c, 32'h06);
    repeat (2) sampleEdge();
    #700;
    prevP = lineP;
    for (int i = 0; i < 8; i++) begin
      sampleEdge();
      #700;
      chk("ones_alt", {31'h0, ~prevP}, {31'h0, lineP});
      chk("ones_mark", 32'h1, {31'h0, lineP ^ lineN});
      prevP = lineP;
    end
    $display("test all ones done");
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h0c, 32'h0);
    monP <= 1'b1;
    #1600;
    chk("alarm_clear", 32'h0, {31'h0, alarm});
    @(posedge core_clk);
    monP <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    #4800;
    chk("alarm_early", 32'h0, {31'h0, alarm});
    chk("irq_idle", 32'h0, {31'h0, irq});
    #4800;
    chk("alarm_set", 32'h1, {31'h0, alarm});
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(1'b0, 8'h14, 32'h0);
    chk("istat_alarm", 32'h1, rd & 32'h1);
    repeat (3) @(posedge core_clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h0c, 32'h24);
    #2400;
    chk("int_monitor", 32'h0, {31'h0, alarm});
    $display("test monitor done");
    apb(1'b1, 8'h10, 32'h3);
    errStep(32'h10, 32'h4);
    errStep(32'h10, 32'h0);
    errStep(32'h00, 32'h0);
    errStep(32'h10, 32'h4);
    apb(1'b1, 8'h10, 32'h1);
    errStep(32'h00, 32'h0);
    errStep(32'h10, 32'h0);
    $display("test error insert done");
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h0c, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("buildout_on", 32'h1, {31'h0, buildout});
    apb(1'b1, 8'h10, 32'h4);
    repeat (2) @(posedge core_clk);
    chk("buildout_e3", 32'h0, {31'h0, buildout});
    $display("test buildout done");
    summarize();
  end
endmodule

`default_nettype wire
